// ### core/diag_pkg.sv
// Offsets, field layouts and reset values of the diagnostic register bank
package diag_pkg;
  localparam logic [7:0] OFS_STATE = 8'h14;
  localparam logic [7:0] OFS_IN_DUTY = 8'h16;
  localparam logic [7:0] OFS_OUT_DUTY = 8'h18;
  localparam logic [7:0] OFS_SINK = 8'h1A;
  localparam logic [7:0] OFS_BOOST = 8'h1C;
  localparam logic [7:0] OFS_DETECT = 8'h1E;
  localparam int NUM_REGS = 6;
  localparam logic [15:0] RST_VIEW = 16'h0000;
  localparam logic [15:0] RST_DETECT = 16'h0800;
  localparam int STATE_W = 5;
  localparam int SINK_W = 12;
  localparam int BOOST_W = 11;
  localparam int DET_RATE_LSB = 12;
  localparam int DET_LAYOUT_LSB = 8;
  localparam int DET_SWITCH_LSB = 3;
  localparam int DET_METHOD_LSB = 0;
  localparam int DET_FIXED_ONE_BIT = 11;

  typedef enum logic [4:0] {
    ST_DISABLED = 5'h00,
    ST_REGULATOR_STARTUP = 5'h01,
    ST_FUSE_READ = 5'h02,
    ST_STANDBY = 5'h03,
    ST_CONVERTER_RAMP_FIRST = 5'h04,
    ST_CONVERTER_RAMP_LAST = 5'h0F,
    ST_NORMAL = 5'h10,
    ST_SHUTDOWN = 5'h11,
    ST_ERROR_RETRY = 5'h12,
    ST_EVERY_STRING_FAILED = 5'h13
  } controller_state_code_t;

  typedef enum logic [2:0] {
    LAYOUT_FOUR = 3'h0,
    LAYOUT_THREE = 3'h1,
    LAYOUT_TWO = 3'h2,
    LAYOUT_PAIRED = 3'h3,
    LAYOUT_SINGLE = 3'h4
  } detected_string_layout_t;

  typedef enum logic [1:0] {
    DIM_PWM = 2'h0,
    DIM_HYBRID = 2'h1,
    DIM_CONST_CURRENT = 2'h2,
    DIM_DIRECT_PWM = 2'h3
  } dim_method_t;

  // Live internal values
  typedef struct packed {
    logic [4:0] controllerStateCode;
    logic [15:0] inputDuty;
    logic [15:0] outputDuty;
    logic [11:0] sinkCurrentCode;
    logic [10:0] boostVoltageCode;
    logic [2:0] detectedDimRate;
    logic [2:0] detectedStringLayout;
    logic [2:0] detectedSwitchRate;
    logic [2:0] detectedDimMethod;
  } live_values_t;

  // Register access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
  } reg_req_t;
endpackage

// ### core/led_driver_diag_regs.sv
// Read-only diagnostic register bank of the LED driver
// How it works
// - Controller state code sits in bits 4-0 with the listed state encodings.
// - Controller state view at offset 14h, resets zero, bits 15-5 zero.
// - Offset 16h shows measured input PWM duty over 16 bits, zero after reset.
// - Offset 18h shows applied output PWM duty over 16 bits, zero after reset.
// - Offset 1Ah shows 12-bit sink current code, bits 15-12 zero.
// - Offset 1Ch shows 11-bit boost voltage code, bits 15-11 zero.
// - Offset 1Eh shows detected setup fields; bit 11 reads one.
// - Dim rate codes 0-7 mean 152 to 19531 Hz.
// - String layout codes 0-4 mean four, three, two, paired, single string.
// - Switch rate codes 0-7 mean 100 to 2222 kHz.
// - Dim method codes 0-3 with one address, 4-7 same methods other address.
`timescale 1ns/1ps
module led_driver_diag_regs
  import diag_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Live values from the controller
  input wire live_values_t liveValues,
  // Register access from the serial slave
  input wire reg_req_t regReq,
  output logic [DATA_W-1:0] regRdata,
  output logic regRvalid,
  output logic regHit,
  // Decoded state and detection summaries
  output logic addressAlternate,
  output logic [1:0] dimMethod,
  output logic stateIsRamp,
  output logic layoutValid
);
  typedef struct packed {
    logic rvalid;
    logic hit;
    logic [1:0] method;
    logic alt;
    logic ramp;
    logic layoutOk;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;
  logic [NUM_REGS*DATA_W-1:0] words;
  logic [2:0] index;
  logic hitNow;

  function automatic logic [2:0] decode_index(input logic [7:0] a);
    logic [2:0] r;
    r = 3'h7;
    unique case (a)
      OFS_STATE: r = 3'h0;
      OFS_IN_DUTY: r = 3'h1;
      OFS_OUT_DUTY: r = 3'h2;
      OFS_SINK: r = 3'h3;
      OFS_BOOST: r = 3'h4;
      OFS_DETECT: r = 3'h5;
      default: r = 3'h7;
    endcase
    return r;
  endfunction

  function automatic logic is_ramp(input logic [4:0] c);
    return (c >= ST_CONVERTER_RAMP_FIRST) && (c <= ST_CONVERTER_RAMP_LAST);
  endfunction

  // View words, index 0 at lowest bits
  always_comb begin
    words = '0;
    words[0*DATA_W +: STATE_W] = liveValues.controllerStateCode;
    words[1*DATA_W +: DATA_W] = liveValues.inputDuty;
    words[2*DATA_W +: DATA_W] = liveValues.outputDuty;
    words[3*DATA_W +: SINK_W] = liveValues.sinkCurrentCode;
    words[4*DATA_W +: BOOST_W] = liveValues.boostVoltageCode;
    words[5*DATA_W + DET_RATE_LSB +: 3] = liveValues.detectedDimRate;
    words[5*DATA_W + DET_FIXED_ONE_BIT] = 1'b1;
    words[5*DATA_W + DET_LAYOUT_LSB +: 3] = liveValues.detectedStringLayout;
    words[5*DATA_W + DET_SWITCH_LSB +: 3] = liveValues.detectedSwitchRate;
    words[5*DATA_W + DET_METHOD_LSB +: 3] = liveValues.detectedDimMethod;
  end

  assign index = decode_index(regReq.addr);
  assign hitNow = regReq.rd && (index != 3'h7);

  always_comb begin
    s_d = s_q;
    s_d.rvalid = regReq.rd;
    s_d.hit = hitNow;
    // Writes fall through with no effect
    s_d.method = liveValues.detectedDimMethod[1:0];
    s_d.alt = liveValues.detectedDimMethod[2];
    s_d.ramp = is_ramp(liveValues.controllerStateCode);
    s_d.layoutOk = liveValues.detectedStringLayout <= LAYOUT_SINGLE;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  view_store #(
    .WIDTH(DATA_W),
    .DEPTH(NUM_REGS)
  ) u_store (
    .clock(clock),
    .sysRst(sys_rst),
    .loadWords(words),
    .readIndex(index),
    .readHit(hitNow),
    .readData(regRdata)
  );

  assign regRvalid = s_q.rvalid;
  assign regHit = s_q.hit;
  assign dimMethod = s_q.method;
  assign addressAlternate = s_q.alt;
  assign stateIsRamp = s_q.ramp;
  assign layoutValid = s_q.layoutOk;
endmodule

// ### core/view_store.sv
// Register array of the six views with registered read port
`timescale 1ns/1ps
module view_store
  import diag_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = NUM_REGS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sysRst,
  // Snapshot load
  input wire logic [DEPTH*WIDTH-1:0] loadWords,
  // Read port
  input wire logic [$clog2(DEPTH)-1:0] readIndex,
  input wire logic readHit,
  output logic [WIDTH-1:0] readData
);
  typedef struct packed {
    logic [DEPTH*WIDTH-1:0] words;
    logic [WIDTH-1:0] data;
  } store_state_t;

  store_state_t s_q;
  store_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.words = loadWords;
    s_d.data = readHit ? s_q.words[readIndex*WIDTH +: WIDTH] : '0;
  end

  always_ff @(posedge clock) begin
    if (sysRst) begin
      s_q.words <= {RST_DETECT, {(DEPTH-1){RST_VIEW}}};
      s_q.data <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign readData = s_q.data;
endmodule

// ### verif/diag_host.sv
// Host model issuing single register accesses
`timescale 1ns/1ps
module diag_host
  import diag_pkg::*;
(
  // Clock and answer
  input wire logic clock,
  input wire logic [15:0] regRdata,
  input wire logic regHit,
  // Request
  output reg_req_t regReq
);
  initial regReq = '0;
  task automatic access(input logic w, input logic [7:0] a, output logic [15:0] d, output logic h);
    @(posedge clock);
    #1 regReq = '{rd: !w, wr: w, addr: a};
    @(posedge clock);
    #1 regReq = '{rd: 1'b0, wr: 1'b0, addr: ~a};
    d = regRdata;
    h = regHit;
  endtask
endmodule

// ### verif/diag_regs_sva.sv
// Port assertions of the diagnostic register bank
`timescale 1ns/1ps
module diag_regs_sva
  import diag_pkg::*;
(
  // Clock, reset, inputs
  input wire logic clock,
  input wire logic sys_rst,
  input wire live_values_t liveValues,
  input wire reg_req_t regReq,
  // Outputs
  input wire logic [15:0] regRdata,
  input wire logic regRvalid,
  input wire logic regHit,
  input wire logic addressAlternate,
  input wire logic [1:0] dimMethod,
  input wire logic stateIsRamp,
  input wire logic layoutValid
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  AST_ANSWER: assert property (!$past(sys_rst) |-> regRvalid == $past(regReq.rd))
    else $error("bad answer");
  AST_HIT: assert property (regRvalid |-> regHit ==
    ($past(regReq.addr) inside {8'h14, 8'h16, 8'h18, 8'h1A, 8'h1C, 8'h1E})) else $error("bad hit");
  AST_STATE: assert property (regReq.rd && regReq.addr == 8'h14 && !$past(sys_rst) |=>
    regRdata == {11'h000, $past(liveValues.controllerStateCode, 2)}) else $error("bad state");
  AST_IN_DUTY: assert property (regReq.rd && regReq.addr == 8'h16 && !$past(sys_rst) |=>
    regRdata == $past(liveValues.inputDuty, 2)) else $error("bad input duty");
  AST_OUT_DUTY: assert property (regReq.rd && regReq.addr == 8'h18 && !$past(sys_rst) |=>
    regRdata == $past(liveValues.outputDuty, 2)) else $error("bad output duty");
  AST_SINK: assert property (regReq.rd && regReq.addr == 8'h1A && !$past(sys_rst) |=>
    regRdata == {4'h0, $past(liveValues.sinkCurrentCode, 2)}) else $error("bad sink");
  AST_BOOST: assert property (regReq.rd && regReq.addr == 8'h1C && !$past(sys_rst) |=>
    regRdata == {5'h00, $past(liveValues.boostVoltageCode, 2)}) else $error("bad boost");
  AST_DETECT: assert property (regReq.rd && regReq.addr == 8'h1E |=>
    regRdata[11] && !regRdata[15] && regRdata[7:6] == 2'h0) else $error("bad detect");
  AST_ALT: assert property (!$past(sys_rst) |->
    {addressAlternate, dimMethod} == $past(liveValues.detectedDimMethod)) else $error("bad method");
  AST_RAMP: assert property (!$past(sys_rst) |->
    stateIsRamp == ($past(liveValues.controllerStateCode) inside {[5'h04:5'h0F]})) else $error("bad ramp");
  AST_LAYOUT: assert property (!$past(sys_rst) |->
    layoutValid == ($past(liveValues.detectedStringLayout) <= 3'h4)) else $error("bad layout");
endmodule
bind led_driver_diag_regs diag_regs_sva CHK (.clock(clock), .sys_rst(sys_rst), .liveValues(liveValues),
  .regReq(regReq), .regRdata(regRdata), .regRvalid(regRvalid), .regHit(regHit),
  .addressAlternate(addressAlternate), .dimMethod(dimMethod), .stateIsRamp(stateIsRamp),
  .layoutValid(layoutValid));

// ### verif/tb.sv
// Testbench of the diagnostic register bank
`timescale 1ns/1ps
module tb;
  import diag_pkg::*;
  logic clock = 0;
  logic sys_rst = 1;
  live_values_t liveValues = '0;
  reg_req_t regReq;
  logic [15:0] regRdata;
  logic regHit;
  int miscompares = 0;
  int checksDone = 0;
  led_driver_diag_regs DUT (.clock(clock), .sys_rst(sys_rst), .liveValues(liveValues), .regReq(regReq),
    .regRdata(regRdata), .regRvalid(), .regHit(regHit), .addressAlternate(), .dimMethod(),
    .stateIsRamp(), .layoutValid());
  diag_host host (.clock(clock), .regRdata(regRdata), .regHit(regHit), .regReq(regReq));
  initial forever #12.5 clock = ~clock;
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic expect_read(input logic [7:0] a, input logic [15:0] e, input logic eh);
    logic [15:0] d;
    logic h;
    host.access(1'b0, a, d, h);
    checksDone++;
    if (d !== e || h !== eh) begin
      miscompares++;
      $display("ERROR %0t read %h got %h hit %b", $time, a, d, h);
    end
  endtask
  task automatic expect_ignored_write(input logic [7:0] a);
    logic [15:0] d;
    logic h;
    host.access(1'b1, a, d, h);
    checksDone++;
    if (d !== 16'h0000 || h !== 1'b0) begin
      miscompares++;
      $display("ERROR %0t write %h answered %h hit %b", $time, a, d, h);
    end
  endtask
  initial begin
    repeat (5) @(posedge clock);
    #1 sys_rst = 0;
    expect_read(OFS_STATE, RST_VIEW, 1);
    expect_read(OFS_IN_DUTY, RST_VIEW, 1);
    expect_read(OFS_OUT_DUTY, RST_VIEW, 1);
    expect_read(OFS_DETECT, RST_DETECT, 1);
    expect_read(8'h20, 16'h0000, 0);
    liveValues = '{5'h13, 16'hA5C3, 16'h5AF0, 12'hFFF, 11'h7FF, 3'h5, 3'h4, 3'h6, 3'h7};
    expect_ignored_write(OFS_SINK);
    expect_read(OFS_IN_DUTY, 16'hA5C3, 1);
    expect_read(OFS_OUT_DUTY, 16'h5AF0, 1);
    expect_read(OFS_SINK, 16'h0FFF, 1);
    expect_read(OFS_BOOST, 16'h07FF, 1);
    expect_read(OFS_DETECT, 16'h5C37, 1);
    for (int i = 0; i < 20; i++) begin
      liveValues.controllerStateCode = i[4:0];
      liveValues.detectedDimRate = i[2:0];
      liveValues.detectedStringLayout = i[2:0];
      liveValues.detectedSwitchRate = i[2:0];
      liveValues.detectedDimMethod = i[2:0];
      expect_read(OFS_STATE, {11'h000, i[4:0]}, 1);
      expect_read(OFS_DETECT, {1'b0, i[2:0], 1'b1, i[2:0], 2'h0, i[2:0], i[2:0]}, 1);
    end
    report_and_stop();
  end
  initial begin
    #20000;
    miscompares++;
    report_and_stop();
  end
endmodule
